// *** rtl/ast_pkg.sv ***
/*
  Shared constants, types and helpers for the asynchronous serial transceiver:
  register offsets, field positions, reset values, oversampling counts, states.
  Assumes an 8-bit software register port with a 3-bit word address.
*/
`default_nettype none
package ast_pkg;
  // Register offsets
  localparam logic [2:0] AST_REG_TXCTL  = 3'h0;
  localparam logic [2:0] AST_REG_RXCTL  = 3'h1;
  localparam logic [2:0] AST_REG_BAUD   = 3'h2;
  localparam logic [2:0] AST_REG_DIVLO  = 3'h3;
  localparam logic [2:0] AST_REG_DIVHI  = 3'h4;
  localparam logic [2:0] AST_REG_TXBUF  = 3'h5;
  localparam logic [2:0] AST_REG_STATUS = 3'h6;
  localparam logic [2:0] AST_REG_RXBUF  = 3'h7;
  // transmit_status_control fields
  localparam int TXC_ENABLE  = 0;
  localparam int TXC_CLOCKED = 1;
  localparam int TXC_NINE    = 2;
  localparam int TXC_NINTH_D = 3;
  localparam int TXC_IRQ_EN  = 4;
  // receive_status_control fields
  localparam int RXC_PORT_EN = 0;
  localparam int RXC_NINE    = 1;
  localparam int RXC_CONT    = 2;
  localparam int RXC_ADDR    = 3;
  localparam int RXC_IRQ_EN  = 4;
  // baud_control fields
  localparam int BDC_INVERT  = 0;
  localparam int BDC_FAST    = 1;
  localparam int BDC_WIDE    = 2;
  // Status fields
  localparam int STS_TX_EMPTY = 0;
  localparam int STS_RX_READY = 1;
  localparam int STS_OVERRUN  = 2;
  localparam int STS_FRAMING  = 3;
  localparam int STS_NINTH    = 4;
  localparam int STS_TX_BUSY  = 5;
  // Reset values
  localparam logic [7:0]  AST_CTL_RESET = 8'h00;
  localparam logic [15:0] AST_DIV_RESET = 16'h0000;
  // Sample ticks per bit, as last phase index and mid-bit index
  localparam logic [3:0] OVS_LAST_SLOW = 4'hF;
  localparam logic [3:0] OVS_LAST_FAST = 4'h3;
  localparam logic [3:0] OVS_HALF_SLOW = 4'h7;
  localparam logic [3:0] OVS_HALF_FAST = 4'h1;
  // Frame lengths in bits with start and stop included, then data bits alone and remote clocks per bit
  localparam logic [3:0] FRAME_BITS_8 = 4'hA;
  localparam logic [3:0] FRAME_BITS_9 = 4'hB;
  localparam logic [3:0] DATA_BITS_8  = 4'h8;
  localparam logic [3:0] DATA_BITS_9  = 4'h9;
  localparam int         FAR_BIT_CLKS = 64;

  typedef enum logic [0:0] {
    AST_TX_IDLE  = 1'b0,
    AST_TX_SHIFT = 1'b1
  } ast_tx_state_t;

  typedef enum logic [1:0] {
    AST_RX_IDLE  = 2'b00,
    AST_RX_START = 2'b01,
    AST_RX_DATA  = 2'b10,
    AST_RX_STOP  = 2'b11
  } ast_rx_state_t;

  // Stop, data LSB first, start; shifted out from bit 0
  function automatic logic [10:0] ast_frame(input logic [8:0] v, input logic nine);
    ast_frame = nine ? {1'b1, v, 1'b0} : {2'b11, v[7:0], 1'b0};
  endfunction
endpackage
`default_nettype wire

// *** rtl/ast_link_if.sv ***
/*
  Serial line between the port and the remote transceiver.
  The port's output pin is undriven (pulled to mark) while its enable is low.
*/
`timescale 1ns/1ps
`default_nettype none
interface ast_link_if;
  logic dev_txd;
  logic dev_txd_oe;
  logic far_txd;
  logic line_to_far;

  // Pull-up keeps an undriven line at mark
  assign line_to_far = dev_txd_oe ? dev_txd : 1'b1;

  modport device (output dev_txd, output dev_txd_oe, input far_txd);
  modport far    (input line_to_far, output far_txd);
endinterface
`default_nettype wire

// *** rtl/ast_baud_gen.sv ***
/*
  Baud generator: divides sys_clk by divisor+1 into a one-cycle sample tick.
  Assumes the divisor is stable while enabled.
*/
`timescale 1ns/1ps
`default_nettype none
module ast_baud_gen
  import ast_pkg::*;
#(
  parameter int DIV_W = 16
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic             enable,
  input  wire logic             wide,
  input  wire logic [DIV_W-1:0] divisor,
  output logic                  tick_q
);
  typedef struct packed {
    logic [DIV_W-1:0] cnt;
    logic             tick;
  } ast_bg_state_t;

  ast_bg_state_t s_q, s_d;
  logic [DIV_W-1:0] limit;

  always_comb begin
    s_d      = s_q;
    s_d.tick = 1'b0;
    // 8-bit mode ignores the high divisor byte
    limit    = wide ? divisor : {{(DIV_W-8){1'b0}}, divisor[7:0]};
    if (!enable) begin
      s_d.cnt = '0;
    end else if (s_q.cnt >= limit) begin
      s_d.cnt  = '0;
      s_d.tick = 1'b1;
    end else begin
      s_d.cnt = s_q.cnt + 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick_q = s_q.tick;
endmodule // ast_baud_gen
`default_nettype wire

// *** rtl/ast_port_dev.sv ***
/*
  Asynchronous serial port, device end: software registers, transmit buffer
  and hidden shift register, receiver with overrun and address detect.
  Assumes the serial input is synchronous to sys_clk.
// Overview of operation
//- Idle line stays mark; NRZ levels
//- Frame: start, eight or nine data, stop
//- Start is space, stop is mark
//- Bit time from 8/16-bit divider
//- LSB first; shared format and rate
//- No hardware parity; ninth bit carries it
//- Shift register hidden; loaded only from buffer
//- Software enables transmitter, async, port
//- Port enable drives serial output pin
//- Empty flag sets when transmitter enabled
//- Buffer write loads idle shift register
//- Queued character loads right after stop
//- Frame starts immediately after load
//- Invert bit flips idle and data
//- Empty flag clear only when queued
//- Empty flag valid second cycle after write
//- Empty flag read-only; request needs enable
//- Software enables transmit request only when needed
//- Ready flag on transfer; request if enabled
//- Nine-bit receive; ninth bit in status
//- Receive needs continuous enable; clearing clears overrun
//- Address mode accepts only ninth-bit-set
//- Address mode off accepts everything
*/
`timescale 1ns/1ps
`default_nettype none
module ast_port_dev
  import ast_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  output logic            tx_irq,
  output logic            rx_irq,
  ast_link_if.device      link
);
  typedef struct packed {
    logic          tx_en;
    logic          clocked;
    logic          tx_nine;
    logic          tx_ninth;
    logic          transmit_irq_enable;
    logic          serial_port_enable;
    logic          rx_nine;
    logic          continuous_receive_enable;
    logic          address_detect_enable;
    logic          receive_irq_enable;
    logic          invert;
    logic          fast;
    logic          wide;
    logic [15:0]   divisor;
    logic [8:0]    txbuf;
    logic          txbuf_full;
    ast_tx_state_t tx_st;
    logic [10:0]   transmit_shift_register;
    logic [3:0]    tx_bits;
    logic [3:0]    tx_ph;
    ast_rx_state_t rx_st;
    logic          rx_last;
    logic [8:0]    receive_shift_register;
    logic [3:0]    rx_bits;
    logic [3:0]    rx_ph;
    logic [8:0]    rxbuf;
    logic          receive_ready_flag;
    logic          overrun_error_flag;
    logic          ferr;
    logic          transmit_buffer_empty_flag;
    logic [7:0]    rdata;
    logic          line;
    logic          line_oe;
    logic          tx_irq;
    logic          rx_irq;
  } ast_dev_state_t;
  ast_dev_state_t s_q, s_d;
  logic           tick;
  logic           async_on;
  logic           tx_on;
  logic           rx_on;
  logic [3:0]     ph_last;
  logic [3:0]     ph_half;
  logic           rxd;
  assign async_on = s_q.serial_port_enable && !s_q.clocked;
  assign tx_on    = async_on && s_q.tx_en;
  assign rx_on    = async_on && s_q.continuous_receive_enable;
  assign ph_last  = s_q.fast ? OVS_LAST_FAST : OVS_LAST_SLOW;
  assign ph_half  = s_q.fast ? OVS_HALF_FAST : OVS_HALF_SLOW;
  assign rxd      = link.far_txd;
  // One rate for both directions
  ast_baud_gen #(.DIV_W(16)) u_baud (.sys_clk(sys_clk), .rst_n(rst_n), .enable(async_on), .wide(s_q.wide),
    .divisor(s_q.divisor), .tick_q(tick));
  always_comb begin
    s_d       = s_q;
    s_d.rdata = 8'h00;
    if (reg_wr) begin
      case (reg_addr)
        AST_REG_TXCTL: begin
          s_d.tx_en    = reg_wdata[TXC_ENABLE];
          s_d.clocked  = reg_wdata[TXC_CLOCKED];
          s_d.tx_nine  = reg_wdata[TXC_NINE];
          s_d.tx_ninth = reg_wdata[TXC_NINTH_D];
          s_d.transmit_irq_enable     = reg_wdata[TXC_IRQ_EN];
        end
        AST_REG_RXCTL: begin
          s_d.serial_port_enable    = reg_wdata[RXC_PORT_EN];
          s_d.rx_nine = reg_wdata[RXC_NINE];
          s_d.continuous_receive_enable    = reg_wdata[RXC_CONT];
          s_d.address_detect_enable   = reg_wdata[RXC_ADDR];
          s_d.receive_irq_enable    = reg_wdata[RXC_IRQ_EN];
        end
        AST_REG_BAUD: begin
          s_d.invert = reg_wdata[BDC_INVERT];
          s_d.fast   = reg_wdata[BDC_FAST];
          s_d.wide   = reg_wdata[BDC_WIDE];
        end
        AST_REG_DIVLO: s_d.divisor[7:0]  = reg_wdata;
        AST_REG_DIVHI: s_d.divisor[15:8] = reg_wdata;
        default: ;
      endcase
    end
    case (s_q.tx_st)
      AST_TX_IDLE: begin
        if (s_q.txbuf_full) begin
          s_d.transmit_shift_register        = ast_frame(s_q.txbuf, s_q.tx_nine);
          s_d.tx_bits    = s_q.tx_nine ? FRAME_BITS_9 : FRAME_BITS_8;
          s_d.tx_ph      = 4'h0;
          s_d.txbuf_full = 1'b0;
          s_d.tx_st      = AST_TX_SHIFT;
        end
      end
      AST_TX_SHIFT: begin
        if (tick) begin
          if (s_q.tx_ph == ph_last) begin
            s_d.tx_ph   = 4'h0;
            s_d.transmit_shift_register     = {1'b1, s_q.transmit_shift_register[10:1]};
            s_d.tx_bits = s_q.tx_bits - 4'h1;
            if (s_q.tx_bits == 4'h1) begin
              if (s_q.txbuf_full) begin
                s_d.transmit_shift_register        = ast_frame(s_q.txbuf, s_q.tx_nine); // Follows the stop bit at once
                s_d.tx_bits    = s_q.tx_nine ? FRAME_BITS_9 : FRAME_BITS_8;
                s_d.txbuf_full = 1'b0;
              end else begin
                s_d.tx_st = AST_TX_IDLE;
              end
            end
          end else begin
            s_d.tx_ph = s_q.tx_ph + 4'h1;
          end
        end
      end
      default: s_d.tx_st = AST_TX_IDLE;
    endcase
    // Writes while disabled are dropped; a full buffer holds the old character
    if (reg_wr && reg_addr == AST_REG_TXBUF && tx_on && !s_q.txbuf_full) begin
      s_d.txbuf      = {s_q.tx_ninth, reg_wdata};
      s_d.txbuf_full = 1'b1;
    end
    if (!tx_on) begin
      s_d.tx_st      = AST_TX_IDLE;
      s_d.txbuf_full = 1'b0;
    end
    // Registered from the buffer state, so it lags a write by one cycle
    s_d.transmit_buffer_empty_flag = tx_on && !s_d.txbuf_full;
    s_d.rx_last = rxd;
    if (reg_rd && reg_addr == AST_REG_RXBUF) begin
      s_d.receive_ready_flag = 1'b0;
      s_d.ferr = 1'b0;
    end
    case (s_q.rx_st)
      AST_RX_IDLE: begin
        if (s_q.rx_last && !rxd && !s_q.overrun_error_flag) begin
          s_d.rx_st = AST_RX_START;
          s_d.rx_ph = 4'h0;
        end
      end
      AST_RX_START: begin
        if (tick) begin
          if (s_q.rx_ph == ph_half) begin
            s_d.rx_ph   = 4'h0;
            s_d.rx_bits = s_q.rx_nine ? DATA_BITS_9 : DATA_BITS_8;
            s_d.rx_st   = rxd ? AST_RX_IDLE : AST_RX_DATA; // Half-bit glitch ignored
          end else begin
            s_d.rx_ph = s_q.rx_ph + 4'h1;
          end
        end
      end
      AST_RX_DATA: begin
        if (tick) begin
          if (s_q.rx_ph == ph_last) begin
            s_d.rx_ph   = 4'h0;
            s_d.receive_shift_register     = {rxd, s_q.receive_shift_register[8:1]};
            s_d.rx_bits = s_q.rx_bits - 4'h1;
            if (s_q.rx_bits == 4'h1) begin
              s_d.rx_st = AST_RX_STOP;
            end
          end else begin
            s_d.rx_ph = s_q.rx_ph + 4'h1;
          end
        end
      end
      AST_RX_STOP: begin
        if (tick) begin
          if (s_q.rx_ph == ph_last) begin
            s_d.rx_st = AST_RX_IDLE;
            if (!(s_q.address_detect_enable && s_q.rx_nine && !s_q.receive_shift_register[8])) begin
              if (!s_d.receive_ready_flag) begin
                s_d.rxbuf = s_q.rx_nine ? s_q.receive_shift_register : {1'b0, s_q.receive_shift_register[8:1]};
                s_d.ferr  = !rxd;
                s_d.receive_ready_flag  = 1'b1;
              end else begin
                s_d.overrun_error_flag = 1'b1; // Held character kept; new one lost
              end
            end
          end else begin
            s_d.rx_ph = s_q.rx_ph + 4'h1;
          end
        end
      end
      default: s_d.rx_st = AST_RX_IDLE;
    endcase
    if (!rx_on) begin
      s_d.rx_st = AST_RX_IDLE;
    end
    if (!s_q.continuous_receive_enable) begin
      s_d.overrun_error_flag = 1'b0;
    end
    // Register reads; shift registers have no address
    if (reg_rd) begin
      case (reg_addr)
        AST_REG_TXCTL:  s_d.rdata = {3'b000, s_q.transmit_irq_enable, s_q.tx_ninth, s_q.tx_nine, s_q.clocked, s_q.tx_en};
        AST_REG_RXCTL:  s_d.rdata = {3'b000, s_q.receive_irq_enable, s_q.address_detect_enable, s_q.continuous_receive_enable, s_q.rx_nine, s_q.serial_port_enable};
        AST_REG_BAUD:   s_d.rdata = {5'b00000, s_q.wide, s_q.fast, s_q.invert};
        AST_REG_DIVLO:  s_d.rdata = s_q.divisor[7:0];
        AST_REG_DIVHI:  s_d.rdata = s_q.divisor[15:8];
        AST_REG_STATUS: s_d.rdata = {2'b00, s_q.tx_st == AST_TX_SHIFT, s_q.rxbuf[8], s_q.ferr, s_q.overrun_error_flag,
                                     s_q.receive_ready_flag, s_q.transmit_buffer_empty_flag};
        AST_REG_RXBUF:  s_d.rdata = s_q.rxbuf[7:0];
        default:        s_d.rdata = 8'h00;
      endcase
    end
    s_d.line    = (s_d.tx_st == AST_TX_SHIFT ? s_d.transmit_shift_register[0] : 1'b1) ^ s_d.invert;
    s_d.line_oe = s_d.serial_port_enable;
    s_d.tx_irq  = s_d.transmit_buffer_empty_flag && s_d.transmit_irq_enable;
    s_d.rx_irq  = s_d.receive_ready_flag && s_d.receive_irq_enable;
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q         <= '0;
      s_q.divisor <= AST_DIV_RESET;
      s_q.rx_last <= 1'b1;
      s_q.line    <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end
  assign reg_rdata       = s_q.rdata;
  assign tx_irq          = s_q.tx_irq;
  assign rx_irq          = s_q.rx_irq;
  assign link.dev_txd    = s_q.line;
  assign link.dev_txd_oe = s_q.line_oe;
endmodule // ast_port_dev
`default_nettype wire

// *** rtl/ast_port_far.sv ***
/*
  Remote transceiver end: sends and receives frames at a fixed bit time.
  Assumes the line from the port is synchronous to sys_clk and non-inverted.
*/
`timescale 1ns/1ps
`default_nettype none
module ast_port_far
  import ast_pkg::*;
#(
  parameter int BIT_CLKS = FAR_BIT_CLKS
) (
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic       nine_bit,
  input  wire logic [8:0] send_data,
  input  wire logic       send_valid,
  output logic            send_ready,
  output logic      [8:0] got_data,
  output logic            got_valid,
  output logic            got_frame_err,
  ast_link_if.far         link
);
  typedef struct packed {
    ast_tx_state_t tx_st;
    logic [10:0]   transmit_shift_register;
    logic [3:0]    tx_bits;
    logic [15:0]   tx_cnt;
    logic          ready;
    logic          txd;
    ast_rx_state_t rx_st;
    logic          rx_last;
    logic [8:0]    receive_shift_register;
    logic [3:0]    rx_bits;
    logic [15:0]   rx_cnt;
    logic [8:0]    got;
    logic          got_v;
    logic          ferr;
  } ast_far_state_t;

  localparam logic [15:0] BIT_LAST  = 16'(BIT_CLKS - 1);
  localparam logic [15:0] HALF_LAST = 16'(BIT_CLKS / 2 - 1);

  ast_far_state_t s_q, s_d;
  logic           rxd;

  assign rxd = link.line_to_far;

  always_comb begin
    s_d       = s_q;
    s_d.got_v = 1'b0;
    case (s_q.tx_st)
      AST_TX_IDLE: begin
        if (send_valid && s_q.ready) begin
          s_d.transmit_shift_register     = ast_frame(send_data, nine_bit);
          s_d.tx_bits = nine_bit ? FRAME_BITS_9 : FRAME_BITS_8;
          s_d.tx_cnt  = 16'h0000;
          s_d.tx_st   = AST_TX_SHIFT;
        end
      end
      AST_TX_SHIFT: begin
        if (s_q.tx_cnt == BIT_LAST) begin
          s_d.tx_cnt  = 16'h0000;
          s_d.transmit_shift_register     = {1'b1, s_q.transmit_shift_register[10:1]};
          s_d.tx_bits = s_q.tx_bits - 4'h1;
          if (s_q.tx_bits == 4'h1) begin
            s_d.tx_st = AST_TX_IDLE;
          end
        end else begin
          s_d.tx_cnt = s_q.tx_cnt + 16'h0001;
        end
      end
      default: s_d.tx_st = AST_TX_IDLE;
    endcase
    s_d.ready = s_d.tx_st == AST_TX_IDLE;
    s_d.txd   = s_d.tx_st == AST_TX_SHIFT ? s_d.transmit_shift_register[0] : 1'b1;

    s_d.rx_last = rxd;
    case (s_q.rx_st)
      AST_RX_IDLE: begin
        if (s_q.rx_last && !rxd) begin
          s_d.rx_cnt = 16'h0000;
          s_d.rx_st  = AST_RX_START;
        end
      end
      AST_RX_START: begin
        if (s_q.rx_cnt == HALF_LAST) begin
          s_d.rx_cnt  = 16'h0000;
          s_d.rx_bits = nine_bit ? DATA_BITS_9 : DATA_BITS_8;
          s_d.rx_st   = rxd ? AST_RX_IDLE : AST_RX_DATA;
        end else begin
          s_d.rx_cnt = s_q.rx_cnt + 16'h0001;
        end
      end
      AST_RX_DATA: begin
        if (s_q.rx_cnt == BIT_LAST) begin
          s_d.rx_cnt  = 16'h0000;
          s_d.receive_shift_register     = {rxd, s_q.receive_shift_register[8:1]};
          s_d.rx_bits = s_q.rx_bits - 4'h1;
          if (s_q.rx_bits == 4'h1) begin
            s_d.rx_st = AST_RX_STOP;
          end
        end else begin
          s_d.rx_cnt = s_q.rx_cnt + 16'h0001;
        end
      end
      AST_RX_STOP: begin
        if (s_q.rx_cnt == BIT_LAST) begin
          s_d.rx_st = AST_RX_IDLE;
          s_d.got   = nine_bit ? s_q.receive_shift_register : {1'b0, s_q.receive_shift_register[8:1]};
          s_d.got_v = 1'b1;
          s_d.ferr  = !rxd;
        end else begin
          s_d.rx_cnt = s_q.rx_cnt + 16'h0001;
        end
      end
      default: s_d.rx_st = AST_RX_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q         <= '0;
      s_q.ready   <= 1'b1;
      s_q.txd     <= 1'b1;
      s_q.rx_last <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign send_ready    = s_q.ready;
  assign got_data      = s_q.got;
  assign got_valid     = s_q.got_v;
  assign got_frame_err = s_q.ferr;
  assign link.far_txd  = s_q.txd;
endmodule // ast_port_far
`default_nettype wire

// *** tb/ast_link_monitor.sv ***
/*
  Checker on the serial line joining the port and the remote end.
  Assumes both ends run BIT_CLKS clocks per bit and a sample tick of TICK_CLKS.
*/
`timescale 1ns/1ps
`default_nettype none
module ast_link_monitor #(
  parameter int BIT_CLKS  = 64,
  parameter int TICK_CLKS = 4
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic dev_txd,
  input wire logic dev_txd_oe,
  input wire logic far_txd,
  input wire logic line_to_far
);
  // Longer low runs are idle time under inverted output
  localparam int IDLE_RUN = 704;
  logic [15:0] dev_low_q;
  logic [15:0] far_low_q;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dev_low_q <= 16'h0000;
      far_low_q <= 16'h0000;
    end else begin
      dev_low_q <= line_to_far ? 16'h0000 : dev_low_q + {15'h0000, dev_low_q != 16'hFFFF};
      far_low_q <= far_txd ? 16'h0000 : far_low_q + {15'h0000, far_low_q != 16'hFFFF};
    end
  end

  default clocking mon_cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence far_start_s;
    $fell(far_txd);
  endsequence
  sequence far_low_bit_s;
    !far_txd [*8];
  endsequence

  chk_reset_idle_mark: assert property ($rose(rst_n) |-> line_to_far && far_txd)
    else $error("line not at mark after reset");
  chk_off_line_mark: assert property (!dev_txd_oe |-> line_to_far)
    else $error("line not mark while port off");
  chk_dev_bit_time: assert property (($rose(line_to_far) && dev_txd_oe && dev_low_q <= IDLE_RUN)
    |-> (dev_low_q % BIT_CLKS == 0 || dev_low_q % BIT_CLKS >= BIT_CLKS - TICK_CLKS))
    else $error("port low run not whole bits");
  chk_far_bit_time: assert property ($rose(far_txd) |-> far_low_q % BIT_CLKS == 0)
    else $error("remote low run not whole bits");
  chk_far_low_bound: assert property (far_low_q <= 10 * BIT_CLKS)
    else $error("remote stop bit missing");
  chk_far_start_hold: assert property (far_start_s |-> far_low_bit_s)
    else $error("remote start bit too short");
  chk_far_mark_hold: assert property ($rose(far_txd) |-> far_txd [*8])
    else $error("remote mark too short");
  chk_dev_level_hold: assert property ($fell(line_to_far) && dev_txd_oe |-> !line_to_far [*8])
    else $error("port space too short");
endmodule // ast_link_monitor
`default_nettype wire

// *** tb/async_serial_transceiver_tb.sv ***
/*
  Self-checking bench: port and remote end joined by the link interface.
  Assumes div 3, slow sampling on the port, giving 64 clocks a bit on both ends.
*/
`timescale 1ns/1ps
`default_nettype none
module async_serial_transceiver_tb
  import ast_pkg::*;
;
  logic       sys_clk, rst_n, reg_wr, reg_rd, tx_irq, rx_irq;
  logic       nine_bit, send_valid, send_ready, got_valid, got_frame_err;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic [8:0] send_data, got_data;
  int         n_errors, checked, d;
  time        t1;

  ast_link_if ast_link_if_i ();
  ast_port_dev ast_port_dev_i (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_irq(tx_irq), .rx_irq(rx_irq),
    .link(ast_link_if_i.device));
  ast_port_far #(.BIT_CLKS(64)) ast_port_far_i (.sys_clk(sys_clk), .rst_n(rst_n), .nine_bit(nine_bit),
    .send_data(send_data), .send_valid(send_valid), .send_ready(send_ready), .got_data(got_data),
    .got_valid(got_valid), .got_frame_err(got_frame_err), .link(ast_link_if_i.far));
  ast_link_monitor #(.BIT_CLKS(64), .TICK_CLKS(4)) ast_link_monitor_i (.sys_clk(sys_clk), .rst_n(rst_n),
    .dev_txd(ast_link_if_i.dev_txd), .dev_txd_oe(ast_link_if_i.dev_txd_oe), .far_txd(ast_link_if_i.far_txd),
    .line_to_far(ast_link_if_i.line_to_far));

  task automatic report_and_stop;
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
    chk({8'h00, reg_rdata & m}, {8'h00, e});
  endtask

  task automatic far_send(input logic [8:0] v);
    @(posedge sys_clk);
    send_data <= v;
    send_valid <= 1'b1;
    @(posedge sys_clk);
    while (send_ready !== 1'b1) @(posedge sys_clk);
    send_valid <= 1'b0;
  endtask

  task automatic wait_got(input logic [8:0] e, input logic [8:0] m);
    int i;
    i = 0;
    do begin
      @(posedge sys_clk);
      i++;
    end while (got_valid !== 1'b1 && i < 1000);
    chk({15'h0000, got_valid}, 16'h0001);
    chk({7'h00, got_data & m}, {7'h00, e});
    chk({15'h0000, got_frame_err}, 16'h0000);
  endtask

  task automatic wait_rx;
    int i;
    for (i = 0; i < 1000 && rx_irq !== 1'b1; i++) @(posedge sys_clk);
    chk({15'h0000, rx_irq}, 16'h0001);
  endtask

  task automatic t_reset_values;
    for (int a = 0; a < 7; a++) rd_chk(3'(a), 8'hFF, 8'h00);
    chk({14'h0000, ast_link_if_i.dev_txd, ast_link_if_i.dev_txd_oe}, 16'h0002);
  endtask

  task automatic t_enable;
    wr(AST_REG_DIVLO, 8'h03);
    wr(AST_REG_RXCTL, 8'h01);
    repeat (3) @(posedge sys_clk);
    chk({15'h0000, ast_link_if_i.dev_txd_oe}, 16'h0001);
    rd_chk(AST_REG_STATUS, 8'h01, 8'h00);
    wr(AST_REG_TXCTL, 8'h01);
    rd_chk(AST_REG_STATUS, 8'hFF, 8'h01);
    chk({15'h0000, tx_irq}, 16'h0000);
  endtask

  task automatic t_tx_b2b;
    wr(AST_REG_TXBUF, 8'hA5);
    wr(AST_REG_TXBUF, 8'h3C);
    repeat (2) @(posedge sys_clk);
    rd_chk(AST_REG_STATUS, 8'h21, 8'h20);
    wait_got(9'h0A5, 9'h0FF);
    t1 = $time;
    wait_got(9'h03C, 9'h0FF);
    d = int'(($time - t1) / 25);
    // Ten 64-clock bits; first start bit may lose up to three clocks
    chk({15'h0000, d >= 637 && d <= 640}, 16'h0001);
    repeat (128) @(posedge sys_clk);
    rd_chk(AST_REG_STATUS, 8'h21, 8'h01);
    wr(AST_REG_TXCTL, 8'h11);
    repeat (3) @(posedge sys_clk);
    chk({15'h0000, tx_irq}, 16'h0001);
    wr(AST_REG_TXCTL, 8'h01);
    repeat (3) @(posedge sys_clk);
    chk({15'h0000, tx_irq}, 16'h0000);
  endtask

  task automatic t_tx_ninth;
    @(posedge sys_clk);
    nine_bit <= 1'b1;
    wr(AST_REG_TXCTL, 8'h0D);
    wr(AST_REG_TXBUF, 8'h5A);
    wait_got(9'h15A, 9'h1FF);
    repeat (128) @(posedge sys_clk);
    wr(AST_REG_TXCTL, 8'h05);
    wr(AST_REG_TXBUF, 8'hA6);
    wait_got(9'h0A6, 9'h1FF);
    repeat (128) @(posedge sys_clk);
    wr(AST_REG_TXCTL, 8'h01);
    nine_bit <= 1'b0;
  endtask

  task automatic t_rx_addr;
    nine_bit <= 1'b1;
    wr(AST_REG_RXCTL, 8'h1F);
    far_send(9'h033);
    repeat (900) @(posedge sys_clk);
    rd_chk(AST_REG_STATUS, 8'h02, 8'h00);
    far_send(9'h1C4);
    wait_rx;
    rd_chk(AST_REG_STATUS, 8'h12, 8'h12);
    rd_chk(AST_REG_RXBUF, 8'hFF, 8'hC4);
    wr(AST_REG_RXCTL, 8'h17);
    far_send(9'h055);
    wait_rx;
    rd_chk(AST_REG_STATUS, 8'h12, 8'h02);
    rd_chk(AST_REG_RXBUF, 8'hFF, 8'h55);
    @(posedge sys_clk);
    nine_bit <= 1'b0;
  endtask

  task automatic t_rx_overrun;
    wr(AST_REG_RXCTL, 8'h15);
    far_send(9'h0C3);
    wait_rx;
    rd_chk(AST_REG_STATUS, 8'h06, 8'h02);
    rd_chk(AST_REG_RXBUF, 8'hFF, 8'hC3);
    far_send(9'h011);
    wait_rx;
    far_send(9'h022);
    repeat (900) @(posedge sys_clk);
    rd_chk(AST_REG_STATUS, 8'h04, 8'h04);
    rd_chk(AST_REG_RXBUF, 8'hFF, 8'h11);
    wr(AST_REG_RXCTL, 8'h11);
    rd_chk(AST_REG_STATUS, 8'h04, 8'h00);
    far_send(9'h033);
    repeat (900) @(posedge sys_clk);
    rd_chk(AST_REG_STATUS, 8'h02, 8'h00);
  endtask

  task automatic t_invert_reset;
    wr(AST_REG_BAUD, 8'h01);
    // Long idle keeps the inverted rest level out of the bit-time check
    repeat (800) @(posedge sys_clk);
    chk({15'h0000, ast_link_if_i.line_to_far}, 16'h0000);
    wr(AST_REG_TXBUF, 8'h0F);
    repeat (32) @(posedge sys_clk);
    chk({15'h0000, ast_link_if_i.line_to_far}, 16'h0001);
    repeat (64) @(posedge sys_clk);
    chk({15'h0000, ast_link_if_i.line_to_far}, 16'h0000);
    repeat (256) @(posedge sys_clk);
    chk({15'h0000, ast_link_if_i.line_to_far}, 16'h0001);
    repeat (800) @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (10) @(posedge sys_clk);
    chk({15'h0000, ast_link_if_i.line_to_far}, 16'h0001);
    rst_n <= 1'b1;
    rd_chk(AST_REG_BAUD, 8'hFF, 8'h00);
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  initial begin
    rst_n = 1'b0;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    nine_bit = 1'b0;
    send_data = 9'h000;
    send_valid = 1'b0;
    n_errors = 0;
    checked = 0;
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_reset_values;
    t_enable;
    t_tx_b2b;
    t_tx_ninth;
    t_rx_overrun;
    t_rx_addr;
    t_invert_reset;
    report_and_stop;
  end

  // Scenarios need about 10500 cycles
  initial begin
    repeat (40000) @(posedge sys_clk);
    n_errors++;
    report_and_stop;
  end
endmodule // async_serial_transceiver_tb
`default_nettype wire
